// file: logic/srp_pkg.sv
// shared constants and types for the socket receive pointer register group
package srp_pkg;
  // byte offsets of the socket registers, most significant byte first
  localparam logic [7:0] RX_RECEIVED_SIZE_OFS = 8'h26;
  localparam logic [7:0] RX_READ_POINTER_OFS = 8'h28;
  localparam logic [7:0] RX_WRITE_POINTER_OFS = 8'h2A;
  localparam logic [7:0] SOCKET_EVENT_MASK_OFS = 8'h2C;
  localparam logic [7:0] IP_FRAGMENT_FIELD_OFS = 8'h2D;
  localparam logic [7:0] LIVENESS_PROBE_INTERVAL_OFS = 8'h2F;
  // reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [15:0] FRAG_RESET = 16'h4000;
  localparam logic [7:0] INTERVAL_RESET = 8'h00;
  // event bit positions
  localparam int EV_SESSION_UP = 0;
  localparam int EV_SESSION_CLOSED = 1;
  localparam int EV_RECEIVE = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_SEND_DONE = 4;
  localparam logic [7:0] EVENT_VALID_BITS = 8'h1F;
  // keep-alive unit: 5 s at 10 MHz
  localparam longint CLK_HZ = 10000000;
  localparam longint PROBE_UNIT_S = 5;
  localparam longint PROBE_UNIT_CYCLES = PROBE_UNIT_S * CLK_HZ;
  // host-side register offsets (designer's choice, APB words)
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_DATA_OFS = 8'h04;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h08;
  // host command register codes
  typedef enum logic [2:0] {
    SRP_OP_NONE, SRP_OP_READ, SRP_OP_WRITE, SRP_OP_RECEIVE_DONE_COMMAND, SRP_OP_SEND, SRP_OP_PROBE, SRP_OP_OPEN
  } srp_op_type;
endpackage : srp_pkg

// file: logic/srp_link_if.sv
// link between the socket register group and its host controller
`timescale 1ns/1ps
`default_nettype none
interface srp_link_if;
  logic req; // one-cycle access strobe
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata; // valid the cycle after req
  logic open_cmd; // one-cycle command pulses
  logic receive_done_command_cmd;
  logic send_cmd;
  logic probe_cmd;
  logic host_irq_low;
  modport device (input req, wr, addr, wdata, open_cmd, receive_done_command_cmd, send_cmd, probe_cmd,
    output rdata, host_irq_low);
  modport host (output req, wr, addr, wdata, open_cmd, receive_done_command_cmd, send_cmd, probe_cmd,
    input rdata, host_irq_low);
endinterface : srp_link_if
`default_nettype wire

// file: logic/srp_device.sv
// device end: socket receive pointers, event mask, fragment field, keep-alive timer
`timescale 1ns/1ps
`default_nettype none
module srp_device #(
  parameter longint PROBE_UNIT = srp_pkg::PROBE_UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  srp_link_if.device link,
  input wire logic rx_data_valid, // one byte received into buffer
  input wire logic [4:0] socket_events, // raw event pulses
  input wire logic socket_summary_flag, // this socket's summary bit
  input wire logic tcp_mode,
  input wire logic state_connected,
  input wire logic [4:0] rx_buffer_size, // in KB, 0..16
  output logic [15:0] rx_commit_pointer,
  output logic [13:0] rx_buffer_offset,
  output logic [15:0] ip_fragment_field,
  output logic [7:0] socket_event_flags,
  output logic liveness_probe
);
  import srp_pkg::*;

  // whole register group in one word; one copy is registered each clock
  typedef struct packed {
    logic [15:0] rd_ptr;
    logic [15:0] committed_rd;
    logic [15:0] wr_ptr;
    logic [7:0] mask;
    logic [15:0] frag;
    logic [7:0] interval;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic irq_n;
    logic traffic_seen;
    logic [35:0] unit_cnt;
    logic [7:0] unit_left;
    logic probe;
  } srp_dev_state_type;

  // current and next copy of the state
  srp_dev_state_type s_reg;
  srp_dev_state_type s_next;

  // helpers shared by the next-state logic and the offset register
  logic [15:0] size_raw;
  logic [15:0] size_cap;
  logic [15:0] buf_mask;
  logic write_hit;

  // size clamp and buffer mask from configured size
  always_comb begin
    size_raw = s_reg.wr_ptr - s_reg.committed_rd;
    buf_mask = (rx_buffer_size == 5'd0) ? 16'h0000 : 16'((32'(rx_buffer_size) << 10) - 32'd1);
    size_cap = (rx_buffer_size == 5'd0) ? 16'h0000 : 16'(32'(rx_buffer_size) << 10);
    if (size_raw > size_cap) begin
      size_raw = size_cap;
    end
    write_hit = link.req && link.wr;
  end

  // single next-state process for the whole register group
  always_comb begin
    s_next = s_reg;
    s_next.probe = 1'b0;
    // read mux, msb at low offset
    if (link.req && !link.wr) begin
      case (link.addr)
        RX_RECEIVED_SIZE_OFS: s_next.rdata = size_raw[15:8];
        RX_RECEIVED_SIZE_OFS + 8'h01: s_next.rdata = size_raw[7:0];
        RX_READ_POINTER_OFS: s_next.rdata = s_reg.rd_ptr[15:8];
        RX_READ_POINTER_OFS + 8'h01: s_next.rdata = s_reg.rd_ptr[7:0];
        RX_WRITE_POINTER_OFS: s_next.rdata = s_reg.wr_ptr[15:8];
        RX_WRITE_POINTER_OFS + 8'h01: s_next.rdata = s_reg.wr_ptr[7:0];
        SOCKET_EVENT_MASK_OFS: s_next.rdata = s_reg.mask;
        IP_FRAGMENT_FIELD_OFS: s_next.rdata = s_reg.frag[15:8];
        IP_FRAGMENT_FIELD_OFS + 8'h01: s_next.rdata = s_reg.frag[7:0];
        LIVENESS_PROBE_INTERVAL_OFS: s_next.rdata = s_reg.interval;
        default: s_next.rdata = 8'h00;
      endcase
    end

    // register writes; read-only ones ignore writes
    if (write_hit) begin
      case (link.addr)
        RX_READ_POINTER_OFS: s_next.rd_ptr[15:8] = link.wdata;
        RX_READ_POINTER_OFS + 8'h01: s_next.rd_ptr[7:0] = link.wdata;
        SOCKET_EVENT_MASK_OFS: s_next.mask = link.wdata;
        IP_FRAGMENT_FIELD_OFS: s_next.frag[15:8] = link.wdata;
        IP_FRAGMENT_FIELD_OFS + 8'h01: s_next.frag[7:0] = link.wdata;
        LIVENESS_PROBE_INTERVAL_OFS: begin
          s_next.interval = link.wdata;
          s_next.unit_cnt = '0;
          s_next.unit_left = link.wdata;
        end
        default: s_next.rd_ptr = s_next.rd_ptr;
      endcase
    end

    // receive command commits pointer the host advanced
    if (link.receive_done_command_cmd) begin
      s_next.committed_rd = s_reg.rd_ptr;
    end

    // received byte advances write pointer, wraps at 16 bits
    if (rx_data_valid) begin
      s_next.wr_ptr = s_reg.wr_ptr + 16'h0001;
    end
    if (rx_data_valid || link.send_cmd) begin
      s_next.traffic_seen = 1'b1;
    end

    // event flags are sticky; only reset clears them
    // received data also raises the receive event when it is unmasked
    s_next.flags = s_reg.flags | (8'(socket_events) & s_reg.mask & EVENT_VALID_BITS);
    if (rx_data_valid && s_reg.mask[EV_RECEIVE]) begin
      s_next.flags[EV_RECEIVE] = 1'b1;
    end
    s_next.irq_n = !(socket_summary_flag && |(s_reg.flags & s_reg.mask));

    // keep-alive: only connected TCP after traffic
    // timer is parked while probing is barred, so the first period is whole
    if (!(tcp_mode && state_connected && s_reg.traffic_seen)) begin
      s_next.unit_cnt = '0;
      s_next.unit_left = s_reg.interval;
    end else if (s_reg.interval != 8'h00) begin
      if (s_reg.unit_cnt == 36'(PROBE_UNIT - 1)) begin
        s_next.unit_cnt = '0;
        if (s_reg.unit_left <= 8'h01) begin
          s_next.probe = 1'b1;
          s_next.unit_left = s_reg.interval;
        end else begin
          s_next.unit_left = s_reg.unit_left - 8'h01;
        end
      end else begin
        s_next.unit_cnt = s_reg.unit_cnt + 36'h1;
      end
    end else if (link.probe_cmd) begin
      s_next.probe = 1'b1;
    end

    // a fresh interval restarts a whole period, even at a period's end
    if (write_hit && link.addr == LIVENESS_PROBE_INTERVAL_OFS) begin
      s_next.unit_cnt = '0;
      s_next.unit_left = link.wdata;
    end

    // open command reinitialises the read, commit and write pointers, last so it wins
    if (link.open_cmd) begin
      s_next.rd_ptr = PTR_RESET;
      s_next.committed_rd = PTR_RESET;
      s_next.wr_ptr = PTR_RESET;
      s_next.traffic_seen = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.rd_ptr <= PTR_RESET;
      s_reg.committed_rd <= PTR_RESET;
      s_reg.wr_ptr <= PTR_RESET;
      s_reg.mask <= MASK_RESET;
      s_reg.frag <= FRAG_RESET;
      s_reg.interval <= INTERVAL_RESET;
      s_reg.flags <= '0;
      s_reg.rdata <= '0;
      s_reg.irq_n <= 1'b1;
      s_reg.traffic_seen <= 1'b0;
      s_reg.unit_cnt <= '0;
      s_reg.unit_left <= '0;
      s_reg.probe <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // buffer offset derived from write pointer, registered
  logic [13:0] offset_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg <= '0;
    end else begin
      offset_reg <= 14'(s_reg.wr_ptr & buf_mask);
    end
  end

  // link side, straight from the state register
  assign link.rdata = s_reg.rdata;
  assign link.host_irq_low = s_reg.irq_n;

  // core side outputs, also registered
  assign rx_commit_pointer = s_reg.committed_rd;
  assign rx_buffer_offset = offset_reg;
  assign ip_fragment_field = s_reg.frag;
  assign socket_event_flags = s_reg.flags;
  assign liveness_probe = s_reg.probe;
endmodule : srp_device
`default_nettype wire

// file: logic/srp_host.sv
// host end: APB slave that turns software orders into link accesses and commands
`timescale 1ns/1ps
`default_nettype none
module srp_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  srp_link_if.host link
);
  import srp_pkg::*;

  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic open_cmd;
    logic receive_done_command_cmd;
    logic send_cmd;
    logic probe_cmd;
    logic capture;
    logic [7:0] rd_byte;
    logic irq_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } srp_host_state_type;

  srp_host_state_type h_reg;
  srp_host_state_type h_next;
  logic access;
  srp_op_type op;

  // one-cycle orders; each command register write yields at most one link action, none for SRP_OP_NONE or code 7
  always_comb begin
    h_next = h_reg;
    h_next.req = 1'b0;
    h_next.open_cmd = 1'b0;
    h_next.receive_done_command_cmd = 1'b0;
    h_next.send_cmd = 1'b0;
    h_next.probe_cmd = 1'b0;
    h_next.pready = 1'b0;
    h_next.pslverr = 1'b0;
    h_next.capture = h_reg.req && !h_reg.wr;
    h_next.irq_n = link.host_irq_low;
    access = psel && penable && !h_reg.pready;
    op = srp_op_type'(pwdata[2:0]);
    if (h_reg.capture) begin
      h_next.rd_byte = link.rdata;
    end
    if (access) begin
      h_next.pready = 1'b1;
      h_next.prdata = 32'h0000_0000;
      if (pwrite) begin
        case (paddr)
          HOST_CMD_OFS: begin
            h_next.addr = pwdata[15:8];
            h_next.wdata = pwdata[23:16];
            case (op)
              SRP_OP_READ: h_next.req = 1'b1;
              SRP_OP_WRITE: begin
                h_next.req = 1'b1;
                h_next.wr = 1'b1;
              end
              SRP_OP_RECEIVE_DONE_COMMAND: h_next.receive_done_command_cmd = 1'b1;
              SRP_OP_SEND: h_next.send_cmd = 1'b1;
              SRP_OP_PROBE: h_next.probe_cmd = 1'b1;
              SRP_OP_OPEN: h_next.open_cmd = 1'b1;
              default: h_next.req = 1'b0;
            endcase
            if (op == SRP_OP_READ) begin
              h_next.wr = 1'b0;
            end
          end
          default: h_next.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          HOST_DATA_OFS: h_next.prdata = {24'h000000, h_reg.rd_byte};
          HOST_STATUS_OFS: h_next.prdata = {30'h0, h_reg.req | h_reg.capture, h_reg.irq_n};
          HOST_CMD_OFS: h_next.prdata = {16'h0000, h_reg.wdata, h_reg.addr};
          default: h_next.pslverr = 1'b1;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_reg <= '0;
      h_reg.irq_n <= 1'b1;
    end else begin
      h_reg <= h_next;
    end
  end

  assign prdata = h_reg.prdata;
  assign pready = h_reg.pready;
  assign pslverr = h_reg.pslverr;
  assign link.req = h_reg.req;
  assign link.wr = h_reg.wr;
  assign link.addr = h_reg.addr;
  assign link.wdata = h_reg.wdata;
  assign link.open_cmd = h_reg.open_cmd;
  assign link.receive_done_command_cmd = h_reg.receive_done_command_cmd;
  assign link.send_cmd = h_reg.send_cmd;
  assign link.probe_cmd = h_reg.probe_cmd;
endmodule : srp_host
`default_nettype wire

// file: verif/srp_link_properties.sv
// concurrent checks on the link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module srp_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic open_cmd,
  input wire logic receive_done_command_cmd,
  input wire logic send_cmd,
  input wire logic probe_cmd,
  input wire logic host_irq_low
);
  logic [7:0] mask_sh, ka_sh;
  logic [15:0] frag_sh, rd_sh;
  logic rd_now;
  logic any_cmd;
  assign rd_now = req && !wr;
  assign any_cmd = open_cmd || receive_done_command_cmd || send_cmd || probe_cmd;
  // shadow of what the host last wrote, so readback can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sh <= 8'hFF;
      ka_sh <= 8'h00;
      frag_sh <= 16'h4000;
      rd_sh <= 16'h0000;
    end else if (open_cmd) begin
      rd_sh <= 16'h0000;
    end else if (req && wr) begin
      case (addr)
        8'h28: rd_sh[15:8] <= wdata;
        8'h29: rd_sh[7:0] <= wdata;
        8'h2C: mask_sh <= wdata;
        8'h2D: frag_sh[15:8] <= wdata;
        8'h2E: frag_sh[7:0] <= wdata;
        8'h2F: ka_sh <= wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cmd_one_cycle: assert property (any_cmd |=> !any_cmd)
    else $error("command pulse longer than one cycle");
  a_one_order: assert property ($onehot0({req, open_cmd, receive_done_command_cmd, send_cmd, probe_cmd}))
    else $error("two link orders in one cycle");
  a_req_pulse: assert property (req |=> !req)
    else $error("access strobe held");
  a_rdata_holds: assert property (!rd_now |=> $stable(rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property ((rd_now && (addr < 8'h26 || addr > 8'h2F)) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mask_readback: assert property ((rd_now && addr == 8'h2C) |=> rdata[4:0] == mask_sh[4:0])
    else $error("event mask readback wrong");
  a_frag_readback: assert property ((rd_now && addr[7:1] == 7'h16 && addr[0]) |=> rdata == frag_sh[15:8])
    else $error("fragment high byte wrong");
  a_interval_back: assert property ((rd_now && addr == 8'h2F) |=> rdata == ka_sh)
    else $error("probe interval readback wrong");
  a_rdptr_readback: assert property ((rd_now && addr[7:1] == 7'h14) |=>
    rdata == ($past(addr) == 8'h28 ? rd_sh[15:8] : rd_sh[7:0]))
    else $error("read pointer readback wrong");
  a_irq_masked_off: assert property (mask_sh[4:0] == 5'h00 |=> host_irq_low)
    else $error("interrupt asserted with every event masked");
endmodule : srp_link_properties
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench: APB host end joined to device end over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, probe;
  logic rx_data_valid = 1'b0, summary = 1'b0, tcp_mode = 1'b0, state_connected = 1'b0;
  logic [4:0] socket_events = 5'h00, buf_kb = 5'h01;
  logic [15:0] commit_ptr, frag;
  logic [13:0] buf_ofs;
  logic [7:0] flags;
  int fail_count = 0, samples_checked = 0;
  srp_link_if link ();
  srp_host srp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  srp_device #(.PROBE_UNIT(4)) srp_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .rx_data_valid(rx_data_valid), .socket_events(socket_events), .socket_summary_flag(summary),
    .tcp_mode(tcp_mode), .state_connected(state_connected), .rx_buffer_size(buf_kb),
    .rx_commit_pointer(commit_ptr), .rx_buffer_offset(buf_ofs), .ip_fragment_field(frag),
    .socket_event_flags(flags), .liveness_probe(probe));
  srp_link_properties srp_link_properties_i (.pclk(pclk), .presetn(presetn), .req(link.req), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .open_cmd(link.open_cmd),
    .receive_done_command_cmd(link.receive_done_command_cmd), .send_cmd(link.send_cmd), .probe_cmd(link.probe_cmd),
    .host_irq_low(link.host_irq_low));
  // 100 ns clock
  always #50 pclk = ~pclk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // apb transfer: waits an edge first so a release never meets a new setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("Error %0t: no ready on the register bus", $time);
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic cmd(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, HOST_CMD_OFS, {8'h00, d, a, 5'h00, op});
  endtask : cmd
  // link byte read: order it, wait for busy to clear, fetch the byte
  task automatic lrd(input logic [7:0] a, output logic [7:0] b);
    int n;
    cmd(SRP_OP_READ, a, 8'h00);
    n = 0;
    do begin
      apb(1'b0, HOST_STATUS_OFS, 32'h0);
      n++;
    end while (q[1] !== 1'b0 && n < 20);
    if (q[1] !== 1'b0) begin
      fail_count++;
      $display("Error %0t: link read still busy", $time);
    end
    apb(1'b0, HOST_DATA_OFS, 32'h0);
    b = q[7:0];
  endtask : lrd
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] hi, lo;
    lrd(a, hi);
    lrd(a + 8'h01, lo);
    v = {hi, lo};
  endtask : rd16
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    cmd(SRP_OP_WRITE, a, d[15:8]);
    cmd(SRP_OP_WRITE, a + 8'h01, d[7:0]);
  endtask : wr16
  // size may move between bytes, so reread until two reads agree
  task automatic rsz(output logic [15:0] v);
    logic [15:0] w;
    int n;
    n = 0;
    rd16(RX_RECEIVED_SIZE_OFS, v);
    do begin
      w = v;
      rd16(RX_RECEIVED_SIZE_OFS, v);
      n++;
    end while (v !== w && n < 4);
    if (v !== w) begin
      fail_count++;
      $display("Error %0t: received size never settled", $time);
    end
  endtask : rsz
  task automatic rx_bytes(input int n);
    rx_data_valid <= 1'b1;
    repeat (n) @(posedge pclk);
    rx_data_valid <= 1'b0;
  endtask : rx_bytes
  // window one edge longer than five periods, so a pulse launched on the last one is seen
  task automatic probes(input logic man, input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    if (man) cmd(SRP_OP_PROBE, 8'h00, 8'h00);
    repeat (41) begin
      @(posedge pclk);
      if (probe === 1'b1) n = n + 16'h0001;
    end
    check(n, exp);
  endtask : probes
  task automatic t_reset();
    logic [15:0] v;
    rd16(RX_READ_POINTER_OFS, v);
    check(v, PTR_RESET);
    rd16(IP_FRAGMENT_FIELD_OFS, v);
    check(v, FRAG_RESET);
    lrd(SOCKET_EVENT_MASK_OFS, v[7:0]);
    check(v[7:0], MASK_RESET);
    lrd(8'h30, v[7:0]);
    check(v[7:0], 8'h00);
    apb(1'b0, 8'h0C, 32'h0);
    check(e, 1'b1);
    wr16(IP_FRAGMENT_FIELD_OFS, 16'h0000);
    @(posedge pclk);
    check(frag, 16'h0000);
  endtask : t_reset
  task automatic t_receive();
    logic [15:0] v;
    rx_bytes(3);
    rsz(v);
    check(v, 16'h0003);
    wr16(RX_READ_POINTER_OFS, 16'h0001);
    rsz(v);
    check(v, 16'h0003);
    cmd(SRP_OP_RECEIVE_DONE_COMMAND, 8'h00, 8'h00);
    @(posedge pclk);
    check(commit_ptr, 16'h0001);
    cmd(SRP_OP_WRITE, 8'h2B, 8'h55);
    rd16(RX_WRITE_POINTER_OFS, v);
    check(v, 16'h0003);
  endtask : t_receive
  task automatic t_wrap();
    logic [15:0] v;
    cmd(SRP_OP_OPEN, 8'h00, 8'h00);
    rd16(RX_WRITE_POINTER_OFS, v);
    check(v, PTR_RESET);
    rx_bytes(1030);
    rsz(v);
    check(v, 16'h0400);
    check(buf_ofs, 14'h0006);
    buf_kb <= 5'h10;
    rx_bytes(64508);
    rd16(RX_WRITE_POINTER_OFS, v);
    check(v, 16'h0002);
    wr16(RX_READ_POINTER_OFS, 16'hFFFF + 16'h0003);
    cmd(SRP_OP_RECEIVE_DONE_COMMAND, 8'h00, 8'h00);
    rsz(v);
    check(v, 16'h0000);
  endtask : t_wrap
  // second reset first: earlier traffic left the receive flag set, and flags have no clear
  task automatic t_events();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(flags, 16'h0000);
    cmd(SRP_OP_WRITE, SOCKET_EVENT_MASK_OFS, 8'h1B);
    for (int i = 0; i < 5; i++) begin
      socket_events <= 5'h01 << i;
      @(posedge pclk);
      socket_events <= 5'h00;
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
    check(flags, 16'h001B);
    check(link.host_irq_low, 1'b1);
    summary <= 1'b1;
    apb(1'b0, HOST_STATUS_OFS, 32'h0);
    check(q[0], 1'b0);
    cmd(SRP_OP_WRITE, SOCKET_EVENT_MASK_OFS, 8'h00);
    apb(1'b0, HOST_STATUS_OFS, 32'h0);
    check(q[0], 1'b1);
  endtask : t_events
  task automatic t_probe();
    {tcp_mode, state_connected} <= 2'b11;
    cmd(SRP_OP_WRITE, LIVENESS_PROBE_INTERVAL_OFS, 8'h02);
    probes(1'b0, 16'h0000);
    cmd(SRP_OP_SEND, 8'h00, 8'h00);
    probes(1'b0, 16'h0005);
    state_connected <= 1'b0;
    probes(1'b1, 16'h0000);
    {tcp_mode, state_connected} <= 2'b01;
    probes(1'b0, 16'h0000);
    tcp_mode <= 1'b1;
    cmd(SRP_OP_WRITE, LIVENESS_PROBE_INTERVAL_OFS, 8'h00);
    probes(1'b1, 16'h0001);
  endtask : t_probe
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // main sequence, then watchdog sized past the longest run
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_receive();
    t_wrap();
    t_events();
    t_probe();
    final_report();
  end
  initial begin
    #9000000;
    fail_count++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
